// File: hw/pmu_regs_params.svh
// register offsets, field positions, reset values and timing counts of the pmu register bank
// Notes on behaviour
// - reset time-out is 65 ms when the timer select bit is 1, else 260 ms
// - supply below threshold: interrupt if response bit is 1, else automatic shutdown
// - supply monitor interrupt is masked after reset; writing 1 unmasks it
// - read-only status bit is 1 while supply is below the threshold
// - four-bit read/write threshold field selects the supply monitor level
// - writing 1 to the hold enable enters low-power hold, 0 wakes
// - pushbutton assertion clears the hold enable bit by itself
// - two scratch bits, read/write, no function, cleared at undervoltage lockout
// - hold-ready flag is set by software before hold, read on wake
// - every register bit returns to default at undervoltage lockout
// - regulator enable bit 1 enables the first step-down regulator
// - phase bit 1 runs switching 180 degrees out of phase
// - mode bit 1 forces PWM at all loads, 0 allows light-load power saving
// - three-bit read/write turn-on delay field used during sequencing
// - regulator fault interrupts pass only while the fault enable bit is 1
// - read-only power-good bit is 1 while the output is above threshold
// - six-bit voltage select field; upper two bits reserved and read-only
`ifndef PMU_REGS_PARAMS_SVH
`define PMU_REGS_PARAMS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define OFS_SYSTEM_CONTROL 8'h00
`define OFS_SYSTEM_SLEEP_FLAGS 8'h01
`define OFS_BUCK1_VOLTAGE_SELECT 8'h20
`define OFS_BUCK1_RESERVED 8'h21
`define OFS_BUCK1_CONTROL 8'h22
`define OFS_LDO6_CONTROL 8'h61
`define OFS_LDO7_VOLTAGE_SELECT 8'h64
`define OFS_LDO7_CONTROL 8'h65
`define OFS_CHARGER_RESERVED 8'h70
`define OFS_CHARGER_TIMER_CONFIG 8'h71
`define OFS_CHARGER_EVENT_STATUS 8'h78
`define OFS_CHARGER_INTERRUPT_CONTROL 8'h79
`define OFS_CHARGER_STATE 8'h7A

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define BIT_RESET_TIMER_SELECT 7
`define BIT_SUPPLY_MONITOR_RESPONSE 6
`define BIT_SUPPLY_MONITOR_IRQ_UNMASK 5
`define BIT_SUPPLY_BELOW_THRESHOLD 4
`define BIT_LOW_POWER_HOLD_ENABLE 5
`define BIT_HOLD_READY_FLAG 1
`define BIT_SHUTDOWN_REQUEST_FLAG 0
`define BIT_REG_ON 7
`define BIT_REG_PHASE 6
`define BIT_REG_MODE 5
`define BIT_FAULT_IRQ_ENABLE 1
`define BIT_POWER_GOOD 0

// ----------------------------------------------------------------
// reset values (status bits read live, stored as zero)
// ----------------------------------------------------------------
`define RST_SYSTEM_CONTROL 8'h47
`define RST_SYSTEM_SLEEP_FLAGS 8'h00
`define RST_BUCK1_VOLTAGE_SELECT 8'h24
`define RST_BUCK1_RESERVED 8'h24
`define RST_BUCK1_CONTROL 8'h0C
`define RST_LDO6_CONTROL 8'h40
`define RST_LDO7_VOLTAGE_SELECT 8'h39
`define RST_LDO7_CONTROL 8'h40
`define RST_CHARGER_RESERVED 8'h50
`define RST_CHARGER_TIMER_CONFIG 8'h28
`define RST_CHARGER_EVENT_STATUS 8'h00
`define RST_CHARGER_INTERRUPT_CONTROL 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_FREQ_HZ 25000000
`define RESET_TIMEOUT_SHORT_MS 65
`define RESET_TIMEOUT_LONG_MS 260
`define TURN_ON_DELAY_UNIT_CYC 25000
`define RESET_TIMEOUT_SHORT_CYC (`RESET_TIMEOUT_SHORT_MS * (`CLK_FREQ_HZ / 1000))
`define RESET_TIMEOUT_LONG_CYC (`RESET_TIMEOUT_LONG_MS * (`CLK_FREQ_HZ / 1000))

`endif

// File: hw/pmu_regs_pkg.sv
// types shared by the pmu register bank
package pmu_regs_pkg;
  typedef enum logic [1:0] {SEQ_OFF, SEQ_DELAY, SEQ_ON, SEQ_HOLD} regSeq_e;
endpackage : pmu_regs_pkg

// File: hw/pmu_sync3.sv
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/10ps
module pmu_sync3 #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic din, // asynchronous pin
  output logic dout // filtered level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RESET_VALUE;
      s2 <= RESET_VALUE;
      s3 <= RESET_VALUE;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // level moves only once the last two stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= RESET_VALUE;
    end else if (s2 == s3) begin
      dout <= s3;
    end
  end
endmodule : pmu_sync3

// File: hw/pmu_system_and_regulator_control_regs.sv
// system supervision and first step-down regulator control register bank
`timescale 1ns/10ps
`include "pmu_regs_params.svh"
module pmu_system_and_regulator_control_regs
  import pmu_regs_pkg::*;
#(
  parameter int RESET_SHORT_CYCLES = `RESET_TIMEOUT_SHORT_CYC,
  parameter int RESET_LONG_CYCLES = `RESET_TIMEOUT_LONG_CYC,
  parameter int DELAY_UNIT_CYCLES = `TURN_ON_DELAY_UNIT_CYC
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic rst_n, // undervoltage lockout reset, active low
  input wire logic regWrite, // register write strobe from serial slave
  input wire logic regRead, // register read strobe from serial slave
  input wire logic [7:0] regAddr, // register address
  input wire logic [7:0] regWdata, // write data
  output logic [7:0] regRdata, // read data, registered
  output logic regAck, // access taken, one cycle
  input wire logic supplyBelowLevel, // comparator: system supply below threshold (pin)
  input wire logic regulatorPowerGood, // comparator: buck1 output above power-good (pin)
  input wire logic pushbuttonInput, // pushbutton asserted, active high (pin)
  input wire logic resetRequest, // start of reset time-out from sequencer
  output logic resetOutputPin_n, // reset output, low during time-out
  output logic [3:0] supplyThresholdSelect, // to supply comparator
  output logic systemShutdown, // automatic shutdown request
  output logic lowPowerHold, // device in low-power hold
  output logic regulatorEnable, // buck1 enable after turn-on delay
  output logic regulatorPhase, // 1: 180 degrees out of phase
  output logic regulatorForcePwm, // 1: fixed-frequency pwm at all loads
  output logic [5:0] outputVoltageSelect, // buck1 voltage code
  output logic irq_n // interrupt output, active low
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] systemControl;
  logic [7:0] systemSleepFlags;
  logic [7:0] buck1VoltageSelect;
  logic [7:0] buck1Control;
  logic supplyLow;
  logic powerGood;
  logic pushbutton;
  logic powerGoodLast;
  logic resetActive;
  logic [31:0] resetCount;
  logic [31:0] delayCount;
  regSeq_e seqState;
  logic [7:0] ldo6Control;
  logic [7:0] ldo7VoltageSelect;
  logic [7:0] ldo7Control;
  logic [7:0] chargerTimerConfig;
  logic [7:0] chargerEventStatus;
  logic [7:0] chargerIrqControl;

  pmu_sync3 #(.RESET_VALUE(1'b0)) syncSupply (
    .clk(clk),
    .rst_n(rst_n),
    .din(supplyBelowLevel),
    .dout(supplyLow)
  );
  pmu_sync3 #(.RESET_VALUE(1'b0)) syncPowerGood (
    .clk(clk),
    .rst_n(rst_n),
    .din(regulatorPowerGood),
    .dout(powerGood)
  );
  pmu_sync3 #(.RESET_VALUE(1'b0)) syncButton (
    .clk(clk),
    .rst_n(rst_n),
    .din(pushbuttonInput),
    .dout(pushbutton)
  );

  logic wrSys;
  logic wrSleep;
  logic wrVsel;
  logic wrCtrl;
  assign wrSys = regWrite && (regAddr == `OFS_SYSTEM_CONTROL);
  assign wrSleep = regWrite && (regAddr == `OFS_SYSTEM_SLEEP_FLAGS);
  assign wrVsel = regWrite && (regAddr == `OFS_BUCK1_VOLTAGE_SELECT);
  assign wrCtrl = regWrite && (regAddr == `OFS_BUCK1_CONTROL);

  // ----------------------------------------------------------------
  // system control
  // ----------------------------------------------------------------
  // status bit 4 is not stored; it is merged live on read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      systemControl <= `RST_SYSTEM_CONTROL;
    end else if (wrSys) begin
      systemControl <= regWdata & 8'hEF;
    end
  end

  // ----------------------------------------------------------------
  // sleep flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      systemSleepFlags <= `RST_SYSTEM_SLEEP_FLAGS;
    end else begin
      if (wrSleep) begin
        systemSleepFlags <= regWdata;
      end
      // the button wins over a simultaneous write of 1
      if (pushbutton) begin
        systemSleepFlags[`BIT_LOW_POWER_HOLD_ENABLE] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // buck1 registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buck1VoltageSelect <= `RST_BUCK1_VOLTAGE_SELECT;
    end else if (wrVsel) begin
      buck1VoltageSelect <= {2'b00, regWdata[5:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buck1Control <= `RST_BUCK1_CONTROL;
    end else if (wrCtrl) begin
      buck1Control <= {regWdata[7:1], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // map rows of the other regulators and the charger
  // ----------------------------------------------------------------
  // storage only so software sees the right defaults; live status bits read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldo6Control <= `RST_LDO6_CONTROL;
      ldo7VoltageSelect <= `RST_LDO7_VOLTAGE_SELECT;
      ldo7Control <= `RST_LDO7_CONTROL;
      chargerTimerConfig <= `RST_CHARGER_TIMER_CONFIG;
      chargerEventStatus <= `RST_CHARGER_EVENT_STATUS;
      chargerIrqControl <= `RST_CHARGER_INTERRUPT_CONTROL;
    end else if (regWrite) begin
      case (regAddr)
        `OFS_LDO6_CONTROL: ldo6Control <= {regWdata[7:1], 1'b0};
        `OFS_LDO7_VOLTAGE_SELECT: ldo7VoltageSelect <= regWdata;
        `OFS_LDO7_CONTROL: ldo7Control <= {regWdata[7:1], 1'b0};
        `OFS_CHARGER_TIMER_CONFIG: chargerTimerConfig <= regWdata;
        `OFS_CHARGER_EVENT_STATUS: chargerEventStatus <= {regWdata[7:4], 4'h0};
        `OFS_CHARGER_INTERRUPT_CONTROL: chargerIrqControl <= regWdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
      regAck <= 1'b0;
    end else begin
      regAck <= regRead || regWrite;
      if (regRead) begin
        case (regAddr)
          `OFS_SYSTEM_CONTROL: begin
            regRdata <= systemControl | {3'b000, supplyLow, 4'h0};
          end
          `OFS_SYSTEM_SLEEP_FLAGS: regRdata <= systemSleepFlags;
          `OFS_BUCK1_VOLTAGE_SELECT: regRdata <= buck1VoltageSelect;
          `OFS_BUCK1_RESERVED: regRdata <= `RST_BUCK1_RESERVED;
          `OFS_BUCK1_CONTROL: begin
            regRdata <= buck1Control | {7'h00, powerGood};
          end
          `OFS_LDO6_CONTROL: regRdata <= ldo6Control;
          `OFS_LDO7_VOLTAGE_SELECT: regRdata <= ldo7VoltageSelect;
          `OFS_LDO7_CONTROL: regRdata <= ldo7Control;
          `OFS_CHARGER_RESERVED: regRdata <= `RST_CHARGER_RESERVED;
          `OFS_CHARGER_TIMER_CONFIG: regRdata <= chargerTimerConfig;
          `OFS_CHARGER_EVENT_STATUS: regRdata <= chargerEventStatus;
          `OFS_CHARGER_INTERRUPT_CONTROL: regRdata <= chargerIrqControl;
          // charger state is live status of a charger that is not modelled here
          `OFS_CHARGER_STATE: regRdata <= 8'h00;
          default: regRdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // supply monitor
  // ----------------------------------------------------------------
  assign supplyThresholdSelect = systemControl[3:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      systemShutdown <= 1'b0;
    end else if (supplyLow && !systemControl[`BIT_SUPPLY_MONITOR_RESPONSE]) begin
      systemShutdown <= 1'b1;
    end else if (!supplyLow) begin
      systemShutdown <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  logic supplyIrq;
  logic faultIrq;
  logic faultPending;
  assign supplyIrq = supplyLow && systemControl[`BIT_SUPPLY_MONITOR_RESPONSE]
    && systemControl[`BIT_SUPPLY_MONITOR_IRQ_UNMASK];

  // fault latches on a power-good fall of an enabled regulator; a write to the buck1 control register clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powerGoodLast <= 1'b0;
      faultPending <= 1'b0;
    end else begin
      powerGoodLast <= powerGood;
      if (powerGoodLast && !powerGood && regulatorEnable) begin
        faultPending <= 1'b1;
      end else if (wrCtrl) begin
        faultPending <= 1'b0;
      end
    end
  end
  assign faultIrq = faultPending && buck1Control[`BIT_FAULT_IRQ_ENABLE];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(supplyIrq || faultIrq);
    end
  end

  // ----------------------------------------------------------------
  // reset time-out
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetActive <= 1'b1;
      resetCount <= 32'h0000_0000;
    end else if (resetRequest) begin
      resetActive <= 1'b1;
      resetCount <= 32'h0000_0000;
    end else if (resetActive) begin
      if (systemControl[`BIT_RESET_TIMER_SELECT]
          ? (resetCount >= 32'(RESET_SHORT_CYCLES - 1))
          : (resetCount >= 32'(RESET_LONG_CYCLES - 1))) begin
        resetActive <= 1'b0;
      end else begin
        resetCount <= resetCount + 32'h0000_0001;
      end
    end
  end
  assign resetOutputPin_n = !resetActive;

  // ----------------------------------------------------------------
  // regulator sequencing
  // ----------------------------------------------------------------
  assign lowPowerHold = systemSleepFlags[`BIT_LOW_POWER_HOLD_ENABLE];
  assign regulatorPhase = buck1Control[`BIT_REG_PHASE];
  assign regulatorForcePwm = buck1Control[`BIT_REG_MODE];
  assign outputVoltageSelect = buck1VoltageSelect[5:0];

  // turn-on waits DELAY field times the unit; hold drops the regulator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seqState <= SEQ_OFF;
      delayCount <= 32'h0000_0000;
      regulatorEnable <= 1'b0;
    end else begin
      case (seqState)
        SEQ_OFF: begin
          regulatorEnable <= 1'b0;
          if (buck1Control[`BIT_REG_ON] && !lowPowerHold) begin
            seqState <= SEQ_DELAY;
            delayCount <= 32'(buck1Control[4:2]) * 32'(DELAY_UNIT_CYCLES);
          end
        end
        SEQ_DELAY: begin
          if (!buck1Control[`BIT_REG_ON]) begin
            seqState <= SEQ_OFF;
          end else if (lowPowerHold) begin
            seqState <= SEQ_HOLD;
          end else if (delayCount == 32'h0000_0000) begin
            seqState <= SEQ_ON;
            regulatorEnable <= 1'b1;
          end else begin
            delayCount <= delayCount - 32'h0000_0001;
          end
        end
        SEQ_ON: begin
          if (!buck1Control[`BIT_REG_ON]) begin
            seqState <= SEQ_OFF;
            regulatorEnable <= 1'b0;
          end else if (lowPowerHold) begin
            seqState <= SEQ_HOLD;
            regulatorEnable <= 1'b0;
          end
        end
        SEQ_HOLD: begin
          regulatorEnable <= 1'b0;
          if (!lowPowerHold) begin
            seqState <= SEQ_OFF;
          end
        end
        default: seqState <= SEQ_OFF;
      endcase
    end
  end
endmodule : pmu_system_and_regulator_control_regs

// File: verification/pmu_regs_checker_properties.sv
// concurrent assertions on the ports of the pmu register bank
`timescale 1ns/10ps
module pmu_regs_checker (
  input wire logic clk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  input wire logic [7:0] regAddr, // address
  input wire logic [7:0] regWdata, // write data
  input wire logic regAck, // access taken
  input wire logic supplyBelowLevel, // supply comparator pin
  input wire logic resetOutputPin_n, // reset output
  input wire logic [3:0] supplyThresholdSelect, // threshold code
  input wire logic systemShutdown, // shutdown request
  input wire logic lowPowerHold, // hold state
  input wire logic regulatorEnable, // regulator on
  input wire logic regulatorPhase, // phase select
  input wire logic regulatorForcePwm, // forced pwm
  input wire logic [5:0] outputVoltageSelect // voltage code
);
  logic [7:0] lastWdata;
  logic holdWr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // helpers: $past of an expression is avoided by registering it here
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastWdata <= 8'h00;
      holdWr <= 1'b0;
    end else begin
      lastWdata <= regWdata;
      holdWr <= regWrite && regAddr == 8'h01 && regWdata[5];
    end
  end
  chk_ack_one_cycle: assert property (1'b1 |=> regAck == ($past(regWrite) || $past(regRead)))
    else $error("ack does not follow the strobe");
  chk_threshold_write: assert property (
    regWrite && regAddr == 8'h00 |=> supplyThresholdSelect == lastWdata[3:0])
    else $error("threshold output does not follow write");
  chk_voltage_write: assert property (
    regWrite && regAddr == 8'h20 |=> outputVoltageSelect == lastWdata[5:0])
    else $error("voltage code does not follow write");
  chk_phase_mode_write: assert property (
    regWrite && regAddr == 8'h22 |=>
    regulatorPhase == lastWdata[6] && regulatorForcePwm == lastWdata[5])
    else $error("phase or pwm output does not follow write");
  chk_hold_entry: assert property ($rose(lowPowerHold) |-> holdWr)
    else $error("hold entered without a write of one");
  chk_hold_enable: assert property (lowPowerHold |=> !regulatorEnable)
    else $error("regulator enabled during hold");
  chk_enable_off: assert property (
    regWrite && regAddr == 8'h22 && !regWdata[7] |-> ##[1:3] !regulatorEnable)
    else $error("regulator stays enabled after clear");
  chk_reset_values: assert property ($rose(rst_n) |->
    supplyThresholdSelect == 4'h7 && outputVoltageSelect == 6'h24 && !lowPowerHold &&
    !regulatorPhase && !regulatorForcePwm && !regulatorEnable)
    else $error("outputs not at defaults after reset");
  chk_rstpin_low: assert property ($rose(rst_n) |-> !resetOutputPin_n [*8])
    else $error("reset output released too early");
  chk_shutdown_cause: assert property ($rose(systemShutdown) |-> $past(supplyBelowLevel))
    else $error("shutdown without low supply");
endmodule : pmu_regs_checker

bind pmu_system_and_regulator_control_regs pmu_regs_checker u_pmu_regs_checker (
  .clk, .rst_n, .regWrite, .regRead, .regAddr, .regWdata, .regAck, .supplyBelowLevel,
  .resetOutputPin_n, .supplyThresholdSelect, .systemShutdown, .lowPowerHold,
  .regulatorEnable, .regulatorPhase, .regulatorForcePwm, .outputVoltageSelect
);

// File: verification/pmu_host_model.sv
// host processor model issuing register accesses
`timescale 1ns/10ps
module pmu_host_model (
  input wire logic clk, // system clock
  input wire logic [7:0] regRdata, // read data
  output logic regWrite, // write strobe
  output logic regRead, // read strobe
  output logic [7:0] regAddr, // address
  output logic [7:0] regWdata // write data
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // one strobe cycle per access; idle lines flip so a stale value never looks valid
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk);
    #1;
    regWrite = wr;
    regRead = !wr;
    regAddr = a;
    regWdata = d;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
    q = regRdata;
  endtask : access
endmodule : pmu_host_model

// File: verification/pmu_system_and_regulator_control_regs_tb.sv
// self-checking testbench of the pmu register bank
`timescale 1ns/10ps
module pmu_system_and_regulator_control_regs_tb;
  logic clk, rst_n, regWrite, regRead, regAck, supplyBelowLevel, regulatorPowerGood;
  logic pushbuttonInput, resetRequest, resetOutputPin_n, systemShutdown, lowPowerHold;
  logic regulatorEnable, regulatorPhase, regulatorForcePwm, irq_n;
  logic [7:0] regAddr, regWdata, regRdata, q, a, d;
  logic [3:0] supplyThresholdSelect;
  logic [5:0] outputVoltageSelect;
  logic [15:0] lfsr = 16'h1D13;
  int error_cnt = 0, num_checks = 0, cyc = 0, n;
  logic [7:0] addrs [8] = '{8'h00, 8'h01, 8'h20, 8'h21, 8'h22, 8'h61, 8'h70, 8'h02};
  logic [7:0] rstv [8] = '{8'h47, 8'h00, 8'h24, 8'h24, 8'h0C, 8'h40, 8'h50, 8'h00};
  pmu_system_and_regulator_control_regs #(.RESET_SHORT_CYCLES(50), .RESET_LONG_CYCLES(200),
    .DELAY_UNIT_CYCLES(4)) u_pmu_system_and_regulator_control_regs (.clk, .rst_n, .regWrite,
    .regRead, .regAddr, .regWdata, .regRdata, .regAck, .supplyBelowLevel, .regulatorPowerGood,
    .pushbuttonInput, .resetRequest, .resetOutputPin_n, .supplyThresholdSelect,
    .systemShutdown, .lowPowerHold, .regulatorEnable, .regulatorPhase, .regulatorForcePwm,
    .outputVoltageSelect, .irq_n);
  pmu_host_model host (.clk, .regRdata, .regWrite, .regRead, .regAddr, .regWdata);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand
  function automatic logic [7:0] expect_reg(input logic [7:0] ad, input logic [7:0] dd);
    case (ad)
      8'h00: return {dd[7:5], supplyBelowLevel, dd[3:0]};
      8'h01: return dd;
      8'h20: return {2'b00, dd[5:0]};
      8'h21: return 8'h24;
      8'h22: return {dd[7:1], regulatorPowerGood};
      8'h61: return {dd[7:1], 1'b0};
      default: return 8'h00;
    endcase
  endfunction : expect_reg
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [7:0] dd);
    host.access(1'b1, ad, dd, q);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] want);
    host.access(1'b0, ad, 8'h00, q);
    check("regRdata", q, want);
  endtask : rd
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step
  task automatic wait_high(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
  endtask : wait_high
  task automatic reset_table;
    for (int i = 0; i < 8; i++) begin
      rd(addrs[i], i == 4 ? {7'h06, regulatorPowerGood} : rstv[i]);
    end
  endtask : reset_table
  task print_verdict;
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    supplyBelowLevel = 1'b0;
    regulatorPowerGood = 1'b0;
    pushbuttonInput = 1'b0;
    resetRequest = 1'b0;
    step(3);
    rst_n = 1'b1;
    wait_high(resetOutputPin_n);
    check("longTimeout", 8'(n >= 198 && n <= 202), 8'h01);
    reset_table();
    wr(8'h00, 8'hC7);
    resetRequest = 1'b1;
    step(1);
    resetRequest = 1'b0;
    wait_high(resetOutputPin_n);
    check("shortTimeout", 8'(n >= 48 && n <= 52), 8'h01);
    regulatorPowerGood = 1'b1;
    for (int i = 0; i < 40; i++) begin
      lfsr = next_rand(lfsr);
      a = i < 12 ? addrs[i % 6] : addrs[lfsr[7:0] % 6];
      lfsr = next_rand(lfsr);
      d = i < 12 ? (i < 6 ? 8'hFF : 8'h00) : lfsr[7:0];
      wr(a, d);
      rd(a, expect_reg(a, d));
    end
    wr(8'h01, 8'h00);
    wr(8'h22, 8'h00);
    wr(8'h00, 8'h47);
    supplyBelowLevel = 1'b1;
    step(8);
    rd(8'h00, 8'h57);
    check("irq_n", 8'(irq_n), 8'h01);
    wr(8'h00, 8'h67);
    step(2);
    check("irq_n", 8'(irq_n), 8'h00);
    wr(8'h00, 8'h27);
    step(2);
    check("systemShutdown", 8'(systemShutdown), 8'h01);
    check("irq_n", 8'(irq_n), 8'h01);
    supplyBelowLevel = 1'b0;
    step(8);
    check("systemShutdown", 8'(systemShutdown), 8'h00);
    rd(8'h00, 8'h27);
    wr(8'h22, 8'h8E);
    wait_high(regulatorEnable);
    check("enableDelay", 8'(n >= 11 && n <= 15), 8'h01);
    regulatorPowerGood = 1'b0;
    step(8);
    check("irq_n", 8'(irq_n), 8'h00);
    rd(8'h22, 8'h8E);
    wr(8'h22, 8'h8C);
    step(2);
    check("irq_n", 8'(irq_n), 8'h01);
    regulatorPowerGood = 1'b1;
    step(8);
    regulatorPowerGood = 1'b0;
    step(8);
    check("irq_n", 8'(irq_n), 8'h01);
    regulatorPowerGood = 1'b1;
    wr(8'h01, 8'h22);
    step(2);
    check("lowPowerHold", 8'(lowPowerHold), 8'h01);
    check("regulatorEnable", 8'(regulatorEnable), 8'h00);
    pushbuttonInput = 1'b1;
    step(8);
    check("lowPowerHold", 8'(lowPowerHold), 8'h00);
    wr(8'h01, 8'h23);
    rd(8'h01, 8'h03);
    pushbuttonInput = 1'b0;
    step(8);
    wr(8'h01, 8'h22);
    wr(8'h01, 8'h02);
    step(1);
    check("lowPowerHold", 8'(lowPowerHold), 8'h00);
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    reset_table();
    print_verdict();
  end
endmodule : pmu_system_and_regulator_control_regs_tb
